/* File: src/mcs_case_selector.sv */
// monitoring case selection and cut-off path output drive
//
// How it works
// - equal channels: all safety outputs off, error
// - settle inputs for configurable delay first
// - case only for its own unique combination
// - sleep flag case active: enter sleep
// - one cut-off path per field position
// - path drives pair and/or universal outputs
// - always off: path held off
// - always on non-safe: pair off, universal on
// - always on safe: path held on
// - unassigned cell behaves as always off
// - universal output polarity high or low active
`include "mcs_defs.svh"

module mcs_case_selector
    import mcs_pkg::*;
#(
    parameter int N_IN = 2,
    parameter int N_CASE = 4,
    parameter int N_PATH = 3,
    parameter int N_UNI = 2,
    parameter int MS_CYCLES = `MCS_CLK_KHZ,
    parameter int CW = (N_CASE > 1) ? $clog2(N_CASE) : 1
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SYS_RST,
    // static control input pins, two channels each
    input wire logic [N_IN-1:0] CTRL_A,
    input wire logic [N_IN-1:0] CTRL_B,
    // input configuration
    input wire logic [N_IN-1:0] IN_USED,
    input wire logic ANTIVAL_EN,
    input wire logic [`MCS_DELAY_W-1:0] DELAY_MS,
    // monitoring case table
    input wire logic [N_CASE-1:0] CASE_EN,
    input wire logic [N_CASE*N_IN-1:0] CASE_COMBO,
    input wire logic [N_CASE*N_IN-1:0] CASE_CARE,
    input wire logic [N_CASE-1:0] CASE_SLEEP,
    input wire logic [N_CASE*N_PATH*`MCS_MODE_W-1:0] CELL_MODE,
    // cut-off path output assignment
    input wire logic [N_PATH-1:0] PATH_PAIR,
    input wire logic [N_PATH*N_UNI-1:0] PATH_UNI,
    input wire logic [N_UNI-1:0] UNI_LOW_ACT,
    // field states of the active field set
    input wire logic [N_PATH-1:0] FIELD_CLEAR,
    // safety switch output pair
    output logic SAFE_PAIR_A,
    output logic SAFE_PAIR_B,
    // universal non-safe outputs
    output logic [N_UNI-1:0] UNI_OUT,
    // status
    output logic [CW-1:0] ACTIVE_CASE,
    output logic CASE_VALID,
    output logic SLEEP_REQ,
    output logic ANTIVAL_ERR,
    output logic CONFIG_ERR,
    output logic SETTLING
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [CW-1:0] case_idx; // last active case
        logic case_valid;        // a case is active
        logic sleep;             // sleep request
        logic pair_on;           // pair on
        logic [N_UNI-1:0] uni;   // universal pin levels
        logic cfg_err;           // overlapping combinations
        logic av_err;            // antivalence error
        logic settling;          // inputs settling
        logic up;                // out of reset
    } mcs_main_t;

    mcs_main_t r, n;

    // filter results
    logic [N_IN-1:0] code;
    logic f_err;
    logic f_settle;

    // lookup results
    logic hit;
    logic [CW-1:0] hit_idx;
    logic dup;
    logic act_now;

    // per path cell behaviour and results
    mcs_cell_t path_mode [N_PATH];
    logic [N_PATH-1:0] path_safe;
    logic [N_PATH-1:0] path_ns;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    // combination of case c fits input code
    function automatic logic fits(input int c,
                                  input logic [N_IN-1:0] v);
        logic [N_IN-1:0] cmb;
        logic [N_IN-1:0] care;
        cmb = CASE_COMBO[c*N_IN +: N_IN];
        care = CASE_CARE[c*N_IN +: N_IN];
        return CASE_EN[c] && (((cmb ^ v) & care) == '0);
    endfunction

    // two enabled cases share some combination
    function automatic logic overlap(input int i, input int j);
        logic [N_IN-1:0] d;
        d = (CASE_COMBO[i*N_IN +: N_IN] ^ CASE_COMBO[j*N_IN +: N_IN])
            & CASE_CARE[i*N_IN +: N_IN] & CASE_CARE[j*N_IN +: N_IN];
        return CASE_EN[i] && CASE_EN[j] && (d == '0);
    endfunction

    // ----------------------------------------
    // input filter
    // ----------------------------------------
    mcs_input_filter #(
        .N_IN(N_IN),
        .MS_CYCLES(MS_CYCLES)
    ) u_filt (
        .clk(CLK),
        .rst(SYS_RST),
        .ch_a(CTRL_A),
        .ch_b(CTRL_B),
        .in_used(IN_USED),
        .antival_en(ANTIVAL_EN),
        .delay_ms(DELAY_MS),
        .code(code),
        .antival_err(f_err),
        .settling(f_settle)
    );

    // ----------------------------------------
    // case lookup
    // ----------------------------------------
    // first fitting case; overlaps flagged as config error
    always_comb begin
        hit = 1'b0;
        hit_idx = '0;
        dup = 1'b0;
        for (int i = 0; i < N_CASE; i++) begin
            if (!hit && fits(i, code)) begin
                hit = 1'b1;
                hit_idx = CW'(i);
            end
            for (int j = i + 1; j < N_CASE; j++) begin
                dup = dup | overlap(i, j);
            end
        end
        // no case while table ambiguous or channels bad
        act_now = hit && !dup && !f_err;
    end

    // ----------------------------------------
    // cut-off paths
    // ----------------------------------------
    // one path per field position of the largest set
    for (genvar p = 0; p < N_PATH; p++) begin : g_path
        always_comb begin
            if (act_now) begin
                path_mode[p] = mcs_cell_t'(CELL_MODE[
                    (int'(hit_idx) * N_PATH + p) * `MCS_MODE_W
                    +: `MCS_MODE_W]);
            end else begin
                path_mode[p] = MCS_CELL_OFF;
            end
        end

        mcs_path_driver u_drv (
            .mode(path_mode[p]),
            .field_clear(FIELD_CLEAR[p]),
            .safe_on(path_safe[p]),
            .nonsafe_on(path_ns[p])
        );
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic any_pair;
        logic pair_ok;
        logic act;
        any_pair = 1'b0;
        pair_ok = 1'b1;
        act = 1'b0;
        n = r;
        n.up = 1'b1;
        n.cfg_err = dup;
        n.av_err = f_err;
        n.settling = f_settle;
        n.case_valid = act_now;
        // keep last index while no case is active
        if (act_now) begin
            n.case_idx = hit_idx;
        end
        // sleep as soon as a flagged case is present
        n.sleep = act_now && CASE_SLEEP[hit_idx];
        // pair on only if every path feeding it is on
        for (int p = 0; p < N_PATH; p++) begin
            if (PATH_PAIR[p]) begin
                any_pair = 1'b1;
                pair_ok = pair_ok & path_safe[p];
            end
        end
        n.pair_on = act_now && any_pair && pair_ok;
        // universal outputs: any assigned path active
        for (int u = 0; u < N_UNI; u++) begin
            act = 1'b0;
            for (int p = 0; p < N_PATH; p++) begin
                act = act | (PATH_UNI[p*N_UNI + u] & path_ns[p]);
            end
            // polarity applied at the pin
            n.uni[u] = (act & act_now) ^ UNI_LOW_ACT[u];
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------
    // outputs, all straight from flops
    // ----------------------------------------
    // both pair pins from one flop, so they can never part
    assign SAFE_PAIR_A = r.pair_on;
    assign SAFE_PAIR_B = r.pair_on;
    assign UNI_OUT = r.uni;
    assign ACTIVE_CASE = r.case_idx;
    assign CASE_VALID = r.case_valid;
    assign SLEEP_REQ = r.sleep;
    assign ANTIVAL_ERR = r.av_err;
    assign CONFIG_ERR = r.cfg_err;
    assign SETTLING = r.settling;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_err_pair_off: assert property (
        f_err |=> !SAFE_PAIR_A && !SAFE_PAIR_B && ANTIVAL_ERR)
        else $error("pair on during antivalence error");
    a_dup_no_case: assert property (
        dup |=> !CASE_VALID && CONFIG_ERR)
        else $error("case active with overlapping table");
    a_sleep_case: assert property (
        act_now && CASE_SLEEP[hit_idx] |=> SLEEP_REQ
            && ACTIVE_CASE == $past(hit_idx))
        else $error("sleep not requested for flagged case");
    a_sleep_cause: assert property (
        SLEEP_REQ |-> CASE_VALID && CASE_SLEEP[ACTIVE_CASE])
        else $error("sleep without flagged active case");
    a_pair_twins: assert property (
        SAFE_PAIR_A == SAFE_PAIR_B)
        else $error("pair channels differ");
    a_off_no_case: assert property (
        !CASE_VALID |-> !SAFE_PAIR_A)
        else $error("pair on with no active case");
    a_off_cell: assert property (
        act_now && (path_mode[0] == MCS_CELL_OFF
            || path_mode[0] == MCS_CELL_NONE) && PATH_PAIR[0]
        |=> !SAFE_PAIR_A)
        else $error("pair on through off cell");
    a_ns_pair_off: assert property (
        path_mode[0] == MCS_CELL_ON_NS |-> !path_safe[0] && path_ns[0])
        else $error("non-safe on cell drives safety on");
    a_safe_on: assert property (
        act_now && PATH_PAIR == N_PATH'(1)
            && path_mode[0] == MCS_CELL_ON_S |=> SAFE_PAIR_A)
        else $error("safe on cell left pair off");
    // idle level follows the polarity seen one edge earlier
    a_uni_idle_pol: assert property (
        r.up && !CASE_VALID |-> UNI_OUT == $past(UNI_LOW_ACT))
        else $error("universal output not at idle level");
    // non-safe pins also rest while channels are bad
    a_err_uni_idle: assert property (
        f_err |=> UNI_OUT == $past(UNI_LOW_ACT))
        else $error("universal output active during antivalence error");
    a_field_follow: assert property (
        path_mode[0] == MCS_CELL_FIELD |-> path_safe[0] == FIELD_CLEAR[0])
        else $error("field path does not follow field");

    c_sleep: cover property (SLEEP_REQ);
    c_err: cover property ($rose(ANTIVAL_ERR));
    c_case_switch: cover property (
        CASE_VALID ##1 CASE_VALID && $changed(ACTIVE_CASE));
    c_pair_on: cover property ($rose(SAFE_PAIR_A));

endmodule

/* File: pkg/mcs_defs.svh */
// constants of the monitoring case selector
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
// system clock in kHz, i.e. cycles per ms
`define MCS_CLK_KHZ 100000
// least settling delay in ms
`define MCS_MIN_DELAY_MS 12

// ----------------------------------------
// field widths and reset values
// ----------------------------------------
`define MCS_DELAY_W 10
`define MCS_MODE_W 3
`define MCS_CNT_W 32
`define MCS_RST_BIT 1'h0

`endif

/* File: pkg/mcs_pkg.sv */
// types of the monitoring case selector
`include "mcs_defs.svh"

package mcs_pkg;

    // ----------------------------------------
    // behaviour of one table cell
    // ----------------------------------------
    typedef enum logic [`MCS_MODE_W-1:0] {
        MCS_CELL_NONE = 3'h0,  // no field assigned
        MCS_CELL_FIELD = 3'h1, // follows a real field
        MCS_CELL_OFF = 3'h2,   // always off
        MCS_CELL_ON_NS = 3'h3, // always on, non-safe
        MCS_CELL_ON_S = 3'h4   // always on, safe
    } mcs_cell_t;

    // ----------------------------------------
    // input settling states
    // ----------------------------------------
    typedef enum logic [0:0] {
        MCS_ST_STABLE = 1'h0,
        MCS_ST_SETTLE = 1'h1
    } mcs_fstate_t;

endpackage

/* File: src/mcs_path_driver.sv */
// output levels of one cut-off path from its cell behaviour
module mcs_path_driver
    import mcs_pkg::*;
(
    // cell behaviour and field state
    input wire mcs_cell_t mode,
    input wire logic field_clear,
    // path results
    output logic safe_on,
    output logic nonsafe_on
);

    // ----------------------------------------
    // behaviour decode
    // ----------------------------------------
    always_comb begin
        case (mode)
            MCS_CELL_FIELD: begin
                safe_on = field_clear;
                nonsafe_on = field_clear;
            end
            MCS_CELL_ON_NS: begin
                safe_on = 1'b0;
                nonsafe_on = 1'b1;
            end
            MCS_CELL_ON_S: begin
                safe_on = 1'b1;
                nonsafe_on = 1'b1;
            end
            // always off, and unassigned cells
            default: begin
                safe_on = 1'b0;
                nonsafe_on = 1'b0;
            end
        endcase
    end

endmodule

/* File: src/mcs_input_filter.sv */
// synchroniser, antivalence check and settling delay of control inputs
`include "mcs_defs.svh"

module mcs_input_filter
    import mcs_pkg::*;
#(
    parameter int N_IN = 2,
    parameter int MS_CYCLES = `MCS_CLK_KHZ
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // raw two-channel pins
    input wire logic [N_IN-1:0] ch_a,
    input wire logic [N_IN-1:0] ch_b,
    // configuration
    input wire logic [N_IN-1:0] in_used,
    input wire logic antival_en,
    input wire logic [`MCS_DELAY_W-1:0] delay_ms,
    // results
    output logic [N_IN-1:0] code,
    output logic antival_err,
    output logic settling
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [N_IN-1:0] a1, b1;  // first sync stage
        logic [N_IN-1:0] a2, b2;  // second sync stage
        logic [N_IN-1:0] pend;    // combination being settled
        logic [N_IN-1:0] stable;  // accepted combination
        logic [`MCS_CNT_W-1:0] cnt;
        mcs_fstate_t st;
        logic err;
    } mcs_filt_t;

    mcs_filt_t r, n;
    logic [N_IN-1:0] cand;
    logic [`MCS_DELAY_W-1:0] eff_ms;
    logic [`MCS_CNT_W-1:0] load;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = r;
        n.a1 = ch_a;
        n.b1 = ch_b;
        n.a2 = r.a1;
        n.b2 = r.b1;
        // channel a carries the value, unused inputs read zero
        cand = r.a2 & in_used;
        // never shorter than the least delay, 1 ms steps
        eff_ms = (delay_ms < `MCS_DELAY_W'(`MCS_MIN_DELAY_MS)) ?
            `MCS_DELAY_W'(`MCS_MIN_DELAY_MS) : delay_ms;
        load = `MCS_CNT_W'(eff_ms) * `MCS_CNT_W'(MS_CYCLES);
        // both channels equal on any used input is an error
        n.err = antival_en & (|(~(r.a2 ^ r.b2) & in_used));
        if (cand != r.pend) begin
            // new combination restarts the settling time
            n.pend = cand;
            n.cnt = load;
            n.st = MCS_ST_SETTLE;
        end else begin
            case (r.st)
                MCS_ST_SETTLE: begin
                    if (r.cnt <= `MCS_CNT_W'(1)) begin
                        n.stable = r.pend;
                        n.st = MCS_ST_STABLE;
                    end else begin
                        n.cnt = r.cnt - `MCS_CNT_W'(1);
                    end
                end
                default: n.st = MCS_ST_STABLE;
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            // idle pins are a low, b high: no false error after reset
            r.b1 <= '1;
            r.b2 <= '1;
        end else begin
            r <= n;
        end
    end

    assign code = r.stable;
    assign antival_err = r.err;
    assign settling = (r.st == MCS_ST_SETTLE);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_settle_only_end: assert property (
        $changed(r.stable) |-> $past(r.st) == MCS_ST_SETTLE
            && $past(r.cnt) <= `MCS_CNT_W'(1))
        else $error("combination taken before settling ended");
    a_delay_least: assert property (
        $changed(r.pend) |-> r.cnt >= `MCS_CNT_W'(`MCS_MIN_DELAY_MS)
            * `MCS_CNT_W'(MS_CYCLES))
        else $error("settling delay below least value");
    a_err_equal_ch: assert property (
        antival_en && (|(~(r.a2 ^ r.b2) & in_used)) |=> r.err)
        else $error("equal channels not flagged");
    c_settle_done: cover property (
        r.st == MCS_ST_SETTLE ##1 r.st == MCS_ST_STABLE);

endmodule

/* File: bench/mcs_ctrl_model.sv */
// machine controller model driving the two-channel static control inputs
module mcs_ctrl_model #(
    parameter int N_IN = 2
) (
    // clock
    input wire logic clk,
    // requested combination, channel faults and bounce length
    input wire logic [N_IN-1:0] combo,
    input wire logic [N_IN-1:0] equal_ch,
    input wire logic [7:0] bounce,
    // two-channel pins
    output logic [N_IN-1:0] ctrl_a,
    output logic [N_IN-1:0] ctrl_b
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [N_IN-1:0] last_combo = '0; // combination last asked for
    int left = 0; // bounce cycles still to go
    int seed = 48; // fixed seed of the bounce pattern
    int rnd; // raw random word
    initial ctrl_a = '0;
    // a slow source bounces for a while, a prompt one switches at once
    always @(posedge clk) begin
        rnd = $random(seed);
        if (combo !== last_combo) begin
            left = int'(bounce);
            last_combo = combo;
        end
        if (left > 0) begin
            left = left - 1;
            ctrl_a <= rnd[N_IN-1:0];
        end else begin
            ctrl_a <= combo;
        end
    end
    // channel b is the inverse of a unless a fault is commanded
    assign ctrl_b = ~ctrl_a ^ equal_ch;
endmodule

/* File: bench/mcs_case_selector_test.sv */
// self-checking bench of the monitoring case selector
`include "mcs_defs.svh"

module mcs_case_selector_test;
    import mcs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NI = 2;
    localparam int NC = 4;
    localparam int NP = 3;
    localparam int NU = 2;
    localparam int MSC = 10;
    // one snapshot of the outputs
    typedef struct packed {
        logic [1:0] pair;
        logic [1:0] uni;
        logic [1:0] cs;
        logic vld;
        logic slp;
        logic aer;
        logic cer;
    } mcs_note_t;
    // ----------------------------------------
    // stimulus and observation signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [NI-1:0] ctrl_a;
    logic [NI-1:0] ctrl_b;
    logic [NI-1:0] combo = 2'h0;
    logic [NI-1:0] eq_ch = 2'h0;
    logic [NI-1:0] in_used = 2'h3;
    logic antival_en = 1'h1;
    logic [`MCS_DELAY_W-1:0] delay_ms = 10'h00C;
    logic [NC-1:0] case_en = 4'hF;
    logic [NC-1:0] case_sleep = 4'h8;
    logic [NC*NI-1:0] case_combo = 8'hE4; // case c matches value c
    logic [NC*NI-1:0] case_care = 8'hFF;
    logic [NC*NP*`MCS_MODE_W-1:0] cell_mode = '0;
    logic [NP-1:0] path_pair = 3'h1;
    logic [NP*NU-1:0] path_uni = 6'h24; // path 1 to uni 0, path 2 to uni 1
    logic [NU-1:0] uni_low_act = 2'h2;
    logic [NP-1:0] field_clear = 3'h7;
    logic [7:0] bounce = 8'h00;
    logic pair_a, pair_b, case_valid, sleep_req, antival_err, config_err;
    logic settling;
    logic [NU-1:0] uni_out;
    logic [1:0] active_case;
    mcs_note_t obs; // outputs as seen
    mcs_note_t exp_n; // oldest expectation
    mcs_note_t notes[$]; // pending expectations
    mcs_cell_t cells[NC][NP]; // case table
    logic chk = 1'b0; // a result is due now
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 48;
    int cur = 0; // case that should be active
    int r, k;
    assign obs = {pair_b, pair_a, uni_out, active_case, case_valid,
                  sleep_req, antival_err, config_err};
    mcs_ctrl_model #(.N_IN(NI)) ctl (.clk(clk), .combo(combo),
        .equal_ch(eq_ch), .bounce(bounce), .ctrl_a(ctrl_a), .ctrl_b(ctrl_b));
    mcs_case_selector #(.N_IN(NI), .N_CASE(NC), .N_PATH(NP), .N_UNI(NU),
        .MS_CYCLES(MSC)) uut (.CLK(clk), .SYS_RST(rst), .CTRL_A(ctrl_a),
        .CTRL_B(ctrl_b), .IN_USED(in_used), .ANTIVAL_EN(antival_en),
        .DELAY_MS(delay_ms), .CASE_EN(case_en), .CASE_COMBO(case_combo),
        .CASE_CARE(case_care), .CASE_SLEEP(case_sleep),
        .CELL_MODE(cell_mode), .PATH_PAIR(path_pair), .PATH_UNI(path_uni),
        .UNI_LOW_ACT(uni_low_act), .FIELD_CLEAR(field_clear),
        .SAFE_PAIR_A(pair_a), .SAFE_PAIR_B(pair_b), .UNI_OUT(uni_out),
        .ACTIVE_CASE(active_case), .CASE_VALID(case_valid),
        .SLEEP_REQ(sleep_req), .ANTIVAL_ERR(antival_err),
        .CONFIG_ERR(config_err), .SETTLING(settling));
    // ----------------------------------------
    // clock, timeout, checking helpers
    // ----------------------------------------
    initial begin
        forever #5 clk = ~clk;
    end
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_sim();
        end
    end
    // compare the oldest note when a result is due
    always @(negedge clk) begin
        if (chk === 1'b1) begin
            exp_n = notes.pop_front();
            cmp("outputs", 16'(exp_n), 16'(obs));
        end
    end
    task automatic cmp(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // expected outputs for case c, error flags given
    function automatic mcs_note_t expect_of(input int c, input logic aer,
                                            input logic cer);
        mcs_note_t n;
        logic pr, s, u;
        logic [NU-1:0] act;
        mcs_cell_t m;
        pr = (path_pair != 3'h0); // no feeding path keeps pair off
        act = '0;
        for (int p = 0; p < NP; p++) begin
            m = cells[c][p];
            s = (m == MCS_CELL_ON_S)
                || (m == MCS_CELL_FIELD && field_clear[p]);
            u = s || (m == MCS_CELL_ON_NS);
            if (path_pair[p] && !s) pr = 1'b0;
            for (int j = 0; j < NU; j++) begin
                if (path_uni[p*NU+j] && u) act[j] = 1'b1;
            end
        end
        if (aer || cer) begin
            pr = 1'b0;
            act = '0;
        end
        n.pair = {pr, pr};
        n.uni = act ^ uni_low_act;
        n.cs = 2'(c);
        n.vld = !(aer || cer);
        n.slp = n.vld && case_sleep[c];
        n.aer = aer;
        n.cer = cer;
        return n;
    endfunction
    // queue a note for the result of the next edge
    task automatic note(input mcs_note_t n);
        notes.push_back(n);
        @(posedge clk);
        chk <= 1'b1;
        @(posedge clk);
        chk <= 1'b0;
    endtask
    // switch to combination c, source bouncing b cycles, delay d ms
    task automatic walk(input int c, input int b, input int d);
        int n, lim;
        logic held;
        lim = (d < 12 ? 12 : d) * MSC;
        n = 0;
        held = 1'b1;
        @(posedge clk);
        delay_ms <= `MCS_DELAY_W'(d);
        bounce <= 8'(b);
        combo <= 2'(c);
        repeat (700) begin
            @(negedge clk);
            if (settling === 1'b1) begin
                n++;
                held = held & (active_case === 2'(cur));
            end
            if (n > 0 && settling === 1'b0) break;
        end
        cmp("settle_len", 16'(n >= lim - 1 && n <= lim + b + 3), 16'h1);
        cmp("held_case", 16'(held), 16'h1);
        cur = c;
        note(expect_of(c, 1'b0, 1'b0));
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        cells = '{'{MCS_CELL_FIELD, MCS_CELL_OFF, MCS_CELL_ON_NS},
                  '{MCS_CELL_ON_S, MCS_CELL_NONE, MCS_CELL_FIELD},
                  '{MCS_CELL_ON_NS, MCS_CELL_ON_S, MCS_CELL_OFF},
                  '{MCS_CELL_FIELD, MCS_CELL_FIELD, MCS_CELL_ON_S}};
        for (int c = 0; c < NC; c++) begin
            for (int p = 0; p < NP; p++) begin
                cell_mode[(c*NP+p)*`MCS_MODE_W +: `MCS_MODE_W] = cells[c][p];
            end
        end
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (200) @(posedge clk);
        // random cases and polarity; odd steps bounce; delays 5, 12 or 20 ms
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            @(posedge clk);
            uni_low_act <= r[4:3];
            path_pair <= r[7:5];
            walk((cur + 1 + (r[9:8] % 3)) % 4, i[0] ? 30 : 0,
                 i == 3 ? 5 : (i == 5 ? 20 : 12));
            @(posedge clk);
            field_clear <= r[2:0];
            #1;
            note(expect_of(cur, 1'b0, 1'b0));
        end
        // overlapping cases, then only one case enabled
        if (cur == 1) walk(2, 0, 12);
        k = cur;
        @(posedge clk);
        case_care <= 8'hF3;
        #1;
        note(expect_of(cur, 1'b0, 1'b1));
        @(posedge clk);
        case_en <= 4'h2;
        #1;
        note(expect_of(1, 1'b0, 1'b0));
        @(posedge clk);
        case_en <= 4'hF;
        case_care <= 8'hFF;
        #1;
        note(expect_of(k, 1'b0, 1'b0));
        // equal channels on each input in turn
        for (int j = 0; j < NI; j++) begin
            @(posedge clk);
            eq_ch <= 2'(1 << j);
            repeat (3) @(posedge clk);
            note(expect_of(cur, 1'b1, 1'b0));
            eq_ch <= 2'h0;
            repeat (200) @(posedge clk);
            note(expect_of(cur, 1'b0, 1'b0));
        end
        // with the check off, equal channels are let through
        @(posedge clk);
        antival_en <= 1'b0;
        eq_ch <= 2'h1;
        repeat (3) @(posedge clk);
        note(expect_of(cur, 1'b0, 1'b0));
        eq_ch <= 2'h0;
        repeat (4) @(posedge clk);
        antival_en <= 1'b1;
        walk((cur + 1) % 4, 0, 12);
        end_sim();
    end
endmodule
